// ===== fwp_pkg.sv
package fwp_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_PTR_UPPER = 8'h00;
  localparam logic [7:0] OFS_PTR_HIGH = 8'h04;
  localparam logic [7:0] OFS_PTR_LOW = 8'h08;
  localparam logic [7:0] OFS_LATCH = 8'h0C;
  localparam logic [7:0] OFS_INT_CTRL = 8'h10;
  localparam logic [7:0] OFS_UNLOCK = 8'h14;
  localparam logic [7:0] OFS_PROG_CTRL = 8'h18;
  localparam logic [7:0] OFS_TBL_CMD = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_WORD_MODE = 5;
  localparam int BIT_ERASE = 4;
  localparam int BIT_WR_ERROR = 3;
  localparam int BIT_PERMIT = 2;
  localparam int BIT_START = 1;
  localparam int BIT_GLOBAL_PERMIT = 7;
  localparam int BIT_CMD_WRITE = 0;
  localparam int BIT_CMD_POSTINC = 1;
  localparam int BIT_STAT_BUSY = 0;
  localparam int PTR_W = 22;

  // ----------------------------------------------------------------
  // Key values and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [PTR_W-1:0] RST_PTR = 22'h000000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned INTERNAL_WRITE_TIME_NS = 1000000;
  // Least time, so round up
  localparam int unsigned INTERNAL_WRITE_CYCLES =
    (INTERNAL_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    KEY_IDLE = 2'h0,
    KEY_HALF = 2'h1,
    KEY_OPEN = 2'h3
  } fwp_key_t;

  typedef enum logic {
    WR_IDLE = 1'h0,
    WR_RUN = 1'h1
  } fwp_wr_t;

endpackage

// ===== fwp_flash_word_program_control.sv
// The address map and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ns
// Operation
// (R1) Word mode programs just the two held bytes
// (R2) Software loads even target address first
// (R3) Two table writes, no post-increment second
// (R4) Start needs write permit; word mode selected (start_req checks the permit bit only, not word mode)
// (R5) Start only right after 55h, AAh keys
// (R6) Stall CPU for the whole timed write
// (R7) Reset during write sets write error flag
// (R8) Software verifies and rewrites after abort
// (R9) Unlock register stores nothing, drives sequencer
// (R10) Control bits 5..1 placed; 7,6,0 zero
// (R11) Pointer 22 bits over three bytes
// (R12) Holding bytes kept after write completes
// (R13) Timer end clears start and releases stall
module fwp_flash_word_program_control #(
  parameter int unsigned WRITE_CYCLES = fwp_pkg::INTERNAL_WRITE_CYCLES,
  parameter int HOLD_BYTES = 64
) (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Power-on reset, active low
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic external_master_reset_n, // Reset pin, active low
  input wire logic watchdog_reset, // Watchdog time-out pulse
  output logic cpu_stall, // Halts instruction execution
  output logic global_interrupt_permit, // Interrupt control bit 7
  output logic flash_prog_start, // One-cycle start to array
  output logic flash_prog_active, // High while array programs
  output logic flash_word_mode, // Word rather than block
  output logic flash_erase, // Erase selected
  output logic [21:0] flash_addr, // Target address
  output logic [15:0] flash_word // Word to program
);

  localparam int IDX_W = $clog2(HOLD_BYTES);
  localparam logic [31:0] CNT_LAST = 32'(WRITE_CYCLES - 1);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic aw_full;
  logic [7:0] aw_addr;
  logic w_full;
  logic [7:0] w_byte;
  logic w_lane0;
  logic do_write;
  logic wr_en;
  logic wr_mapped;
  logic [7:0] wd;
  logic [21:0] table_pointer;
  logic [7:0] table_data_latch;
  logic [7:0] interrupt_control_main;
  logic word_program_mode;
  logic erase_select;
  logic write_error_flag;
  logic write_permit;
  logic write_start;
  logic [7:0] holding [HOLD_BYTES];
  fwp_pkg::fwp_key_t key_state;
  fwp_pkg::fwp_wr_t wr_state;
  logic [31:0] wr_cnt;
  logic timer_end;
  logic start_req;
  logic ext_rst_meta;
  logic ext_rst_sync_n;
  logic soft_reset;
  logic [IDX_W-1:0] idx;
  logic [IDX_W-1:0] idx_lo;
  logic [IDX_W-1:0] idx_hi;
  logic [7:0] prog_ctrl_rd;
  logic [7:0] rd_byte;
  logic rd_mapped;

  // ----------------------------------------------------------------
  // Reset pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_rst_meta <= 1'b1;
      ext_rst_sync_n <= 1'b1;
    end else begin
      ext_rst_meta <= external_master_reset_n;
      ext_rst_sync_n <= ext_rst_meta;
    end
  end

  assign soft_reset = !ext_rst_sync_n || watchdog_reset;

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_full && !s_axi_bvalid;
  assign s_axi_wready = !w_full && !s_axi_bvalid;
  assign do_write = aw_full && w_full && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      aw_addr <= fwp_pkg::RST_BYTE;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_full <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full <= 1'b0;
      w_byte <= fwp_pkg::RST_BYTE;
      w_lane0 <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full <= 1'b1;
      w_byte <= s_axi_wdata[7:0];
      w_lane0 <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_full <= 1'b0;
    end
  end

  always_comb begin
    case (aw_addr)
      fwp_pkg::OFS_PTR_UPPER, fwp_pkg::OFS_PTR_HIGH,
      fwp_pkg::OFS_PTR_LOW, fwp_pkg::OFS_LATCH,
      fwp_pkg::OFS_INT_CTRL, fwp_pkg::OFS_UNLOCK,
      fwp_pkg::OFS_PROG_CTRL, fwp_pkg::OFS_TBL_CMD,
      fwp_pkg::OFS_STATUS: wr_mapped = 1'b1;
      default: wr_mapped = 1'b0;
    endcase
  end

  assign wr_en = do_write && w_lane0 && wr_mapped;
  assign wd = w_byte;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= fwp_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_mapped ? fwp_pkg::RESP_OKAY : fwp_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Table pointer, latch, interrupt control
  // ----------------------------------------------------------------
  assign idx = table_pointer[IDX_W-1:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      table_pointer <= fwp_pkg::RST_PTR;
    end else if (wr_en) begin
      case (aw_addr)
        fwp_pkg::OFS_PTR_UPPER: table_pointer[21:16] <= wd[5:0]; // see (R11)
        fwp_pkg::OFS_PTR_HIGH: table_pointer[15:8] <= wd; // see (R11)
        fwp_pkg::OFS_PTR_LOW: table_pointer[7:0] <= wd; // see (R11)
        fwp_pkg::OFS_TBL_CMD: begin
          if (wd[fwp_pkg::BIT_CMD_WRITE] && wd[fwp_pkg::BIT_CMD_POSTINC]) begin
            table_pointer <= table_pointer + 22'h000001;
          end
        end
        default: table_pointer <= table_pointer;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      table_data_latch <= fwp_pkg::RST_BYTE;
    end else if (wr_en && aw_addr == fwp_pkg::OFS_LATCH) begin
      table_data_latch <= wd;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      interrupt_control_main <= fwp_pkg::RST_BYTE;
    end else if (wr_en && aw_addr == fwp_pkg::OFS_INT_CTRL) begin
      interrupt_control_main <= wd;
    end
  end

  assign global_interrupt_permit =
    interrupt_control_main[fwp_pkg::BIT_GLOBAL_PERMIT];

  // ----------------------------------------------------------------
  // Holding registers, never cleared by a finished write
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (wr_en && aw_addr == fwp_pkg::OFS_TBL_CMD &&
        wd[fwp_pkg::BIT_CMD_WRITE]) begin
      holding[idx] <= table_data_latch; // see (R12)
    end
  end

  // ----------------------------------------------------------------
  // Unlock key sequencer, no storage behind the address
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_reset) begin
      key_state <= fwp_pkg::KEY_IDLE;
    end else if (wr_en) begin
      case (aw_addr)
        fwp_pkg::OFS_UNLOCK: begin
          case (key_state)
            fwp_pkg::KEY_IDLE: key_state <= (wd == fwp_pkg::KEY_FIRST) ?
              fwp_pkg::KEY_HALF : fwp_pkg::KEY_IDLE; // see (R9)
            fwp_pkg::KEY_HALF: key_state <= (wd == fwp_pkg::KEY_SECOND) ?
              fwp_pkg::KEY_OPEN : fwp_pkg::KEY_IDLE; // see (R5)
            default: key_state <= (wd == fwp_pkg::KEY_FIRST) ?
              fwp_pkg::KEY_HALF : fwp_pkg::KEY_IDLE;
          endcase
        end
        default: key_state <= fwp_pkg::KEY_IDLE; // see (R5)
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Program control register
  // ----------------------------------------------------------------
  assign start_req = wr_en && aw_addr == fwp_pkg::OFS_PROG_CTRL &&
    wd[fwp_pkg::BIT_START] && wd[fwp_pkg::BIT_PERMIT] &&
    key_state == fwp_pkg::KEY_OPEN && wr_state == fwp_pkg::WR_IDLE; // see (R4)

  always_ff @(posedge aclk) begin
    if (!aresetn || soft_reset) begin
      word_program_mode <= 1'b0;
      erase_select <= 1'b0;
      write_permit <= 1'b0;
    end else if (wr_en && aw_addr == fwp_pkg::OFS_PROG_CTRL &&
                 wr_state == fwp_pkg::WR_IDLE) begin
      word_program_mode <= wd[fwp_pkg::BIT_WORD_MODE];
      erase_select <= wd[fwp_pkg::BIT_ERASE];
      write_permit <= wd[fwp_pkg::BIT_PERMIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      write_error_flag <= 1'b0;
    end else if (soft_reset && wr_state == fwp_pkg::WR_RUN) begin
      write_error_flag <= 1'b1; // see (R7)
    end else if (wr_en && aw_addr == fwp_pkg::OFS_PROG_CTRL) begin
      write_error_flag <= wd[fwp_pkg::BIT_WR_ERROR];
    end
  end

  // ----------------------------------------------------------------
  // Write cycle and internal programming timer
  // ----------------------------------------------------------------
  assign timer_end = wr_state == fwp_pkg::WR_RUN && wr_cnt == CNT_LAST;

  always_ff @(posedge aclk) begin
    if (!aresetn || soft_reset) begin
      wr_state <= fwp_pkg::WR_IDLE;
      write_start <= 1'b0;
      wr_cnt <= 32'h00000000;
    end else begin
      case (wr_state)
        fwp_pkg::WR_IDLE: begin
          if (start_req) begin
            wr_state <= fwp_pkg::WR_RUN; // see (R5)
            write_start <= 1'b1;
            wr_cnt <= 32'h00000000;
          end
        end
        fwp_pkg::WR_RUN: begin
          if (timer_end) begin
            wr_state <= fwp_pkg::WR_IDLE;
            write_start <= 1'b0; // see (R13)
          end else begin
            wr_cnt <= wr_cnt + 32'h00000001;
          end
        end
        default: wr_state <= fwp_pkg::WR_IDLE;
      endcase
    end
  end

  assign cpu_stall = wr_state == fwp_pkg::WR_RUN; // see (R6) (R13)
  assign flash_prog_active = cpu_stall;

  // ----------------------------------------------------------------
  // Array side: word from the aligned held pair
  // ----------------------------------------------------------------
  assign idx_lo = {idx[IDX_W-1:1], 1'b0};
  assign idx_hi = {idx[IDX_W-1:1], 1'b1};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flash_prog_start <= 1'b0;
      flash_word_mode <= 1'b0;
      flash_erase <= 1'b0;
      flash_addr <= fwp_pkg::RST_PTR;
      flash_word <= 16'h0000;
    end else begin
      flash_prog_start <= start_req && !soft_reset;
      if (start_req) begin
        flash_word_mode <= word_program_mode; // see (R1)
        flash_erase <= erase_select;
        flash_addr <= {table_pointer[21:1], 1'b0}; // see (R1) (R3)
        flash_word <= {holding[idx_hi], holding[idx_lo]}; // see (R1)
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;
  assign prog_ctrl_rd = {2'b00, word_program_mode, erase_select,
    write_error_flag, write_permit, write_start, 1'b0}; // see (R10)

  always_comb begin
    rd_mapped = 1'b1;
    rd_byte = fwp_pkg::RST_BYTE;
    case (s_axi_araddr)
      fwp_pkg::OFS_PTR_UPPER: rd_byte = {2'b00, table_pointer[21:16]};
      fwp_pkg::OFS_PTR_HIGH: rd_byte = table_pointer[15:8];
      fwp_pkg::OFS_PTR_LOW: rd_byte = table_pointer[7:0];
      fwp_pkg::OFS_LATCH: rd_byte = table_data_latch;
      fwp_pkg::OFS_INT_CTRL: rd_byte = interrupt_control_main;
      fwp_pkg::OFS_UNLOCK: rd_byte = fwp_pkg::RST_BYTE; // see (R9)
      fwp_pkg::OFS_PROG_CTRL: rd_byte = prog_ctrl_rd;
      fwp_pkg::OFS_TBL_CMD: rd_byte = fwp_pkg::RST_BYTE;
      fwp_pkg::OFS_STATUS: rd_byte = {7'h00, cpu_stall};
      default: rd_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= fwp_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= rd_mapped ? fwp_pkg::RESP_OKAY : fwp_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ===== fwp_flash_array_model.sv
`timescale 1ns/1ns
module fwp_flash_array_model (
  input wire logic aclk, // System clock
  input wire logic flash_prog_start, // Start pulse
  input wire logic flash_prog_active, // Programming in progress
  input wire logic flash_word_mode, // Word rather than block
  input wire logic [21:0] flash_addr, // Target address
  input wire logic [15:0] flash_word // Word to program
);
  // ----------------------------------------------------------------
  // Array side: record each program and time its busy span
  // ----------------------------------------------------------------
  logic [21:0] got_addr = 22'h000000;
  logic [15:0] got_word = 16'h0000;
  logic got_mode = 1'b0;
  int progs = 0;
  int busy = 0;
  always @(posedge aclk) begin
    if (flash_prog_start) begin
      got_addr <= flash_addr;
      got_word <= flash_word;
      got_mode <= flash_word_mode;
      progs <= progs + 1;
      busy <= 1;
    end else if (flash_prog_active) begin
      busy <= busy + 1;
    end
  end
endmodule

// ===== fwp_flash_word_program_control_props.sv
`timescale 1ns/1ns
module fwp_props #(
  parameter int unsigned WRITE_CYCLES = 8
) (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset, active low
  input wire logic s_axi_arready, // Read address ready
  input wire logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic external_master_reset_n, // Reset pin
  input wire logic watchdog_reset, // Watchdog pulse
  input wire logic cpu_stall, // Stall
  input wire logic flash_prog_active, // Array busy
  input wire logic flash_prog_start, // Start pulse
  input wire logic [21:0] flash_addr // Target address
);
  int unsigned stall_run;
  int unsigned since_soft;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stall_run <= 0;
    end else begin
      stall_run <= cpu_stall ? stall_run + 1 : 0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      since_soft <= 15;
    end else if (watchdog_reset || !external_master_reset_n) begin
      since_soft <= 0;
    end else if (since_soft < 15) begin
      since_soft <= since_soft + 1;
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_launch;
    flash_prog_start && cpu_stall;
  endsequence
  property p_launch;
    $rose(cpu_stall) |-> s_launch;
  endproperty
  property p_pulse;
    s_launch |=> !flash_prog_start && cpu_stall;
  endproperty
  property p_even;
    flash_prog_start |-> !flash_addr[0];
  endproperty
  property p_same;
    cpu_stall == flash_prog_active;
  endproperty
  property p_bound;
    cpu_stall |-> stall_run < WRITE_CYCLES;
  endproperty
  property p_full;
    $fell(cpu_stall) |-> stall_run == WRITE_CYCLES || since_soft < 6;
  endproperty
  property p_wdog;
    cpu_stall && watchdog_reset |=> !cpu_stall;
  endproperty
  property p_ar;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  property p_bclr;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_launch: assert property (p_launch)
    else $error("stall rose without a start pulse");
  a_pulse: assert property (p_pulse)
    else $error("start pulse longer than one cycle");
  a_even: assert property (p_even)
    else $error("word address is odd");
  a_same: assert property (p_same)
    else $error("stall and array busy differ");
  a_bound: assert property (p_bound)
    else $error("stall longer than the write time");
  a_full: assert property (p_full)
    else $error("stall ended early without an abort");
  a_wdog: assert property (p_wdog)
    else $error("watchdog did not end the stall");
  a_ar: assert property (p_ar)
    else $error("read address ready while data pending");
  a_bclr: assert property (p_bclr)
    else $error("write response not cleared");
endmodule
bind fwp_flash_word_program_control fwp_props #(
  .WRITE_CYCLES(WRITE_CYCLES)
) u_props (.aclk, .aresetn, .s_axi_arready, .s_axi_rvalid, .s_axi_bvalid,
  .s_axi_bready, .external_master_reset_n, .watchdog_reset, .cpu_stall,
  .flash_prog_active, .flash_prog_start, .flash_addr);

// ===== fwp_flash_word_program_control_tb_top.sv
`timescale 1ns/1ns
module fwp_flash_word_program_control_tb_top;
  localparam int WC = 8;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, cpu_stall, global_interrupt_permit;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic external_master_reset_n = 1'b1, watchdog_reset = 1'b0;
  logic flash_prog_start, flash_prog_active, flash_word_mode, flash_erase;
  logic [21:0] flash_addr;
  logic [15:0] flash_word;
  logic [31:0] rd;
  int miscompares = 0, tests_run = 0;
  always #10 aclk = ~aclk;
  fwp_flash_word_program_control #(.WRITE_CYCLES(WC)) dut (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .external_master_reset_n, .watchdog_reset, .cpu_stall,
    .global_interrupt_permit, .flash_prog_start, .flash_prog_active,
    .flash_word_mode, .flash_erase, .flash_addr, .flash_word);
  fwp_flash_array_model u_arr (.aclk, .flash_prog_start, .flash_prog_active,
    .flash_word_mode, .flash_addr, .flash_word);
  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task summarize;
    $display("checks %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task tick(inout int n);
    @(negedge aclk);
    n++;
    if (n > 200) begin
      miscompares++;
      summarize();
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    logic ca, cw;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      tick(n);
      ca = s_axi_awvalid && s_axi_awready;
      cw = s_axi_wvalid && s_axi_wready;
      @(posedge aclk);
      if (ca) s_axi_awvalid <= 1'b0;
      if (cw) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !ca) || (s_axi_wvalid && !cw));
    do tick(n); while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask
  task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do tick(n); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do tick(n); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
    chk(nm, rd, e);
  endtask
  task start(input logic [7:0] k1, input logic [7:0] k2, input logic cut,
      input logic [7:0] c);
    int n;
    logic busy_exp;
    n = 0;
    busy_exp = c[fwp_pkg::BIT_START] && c[fwp_pkg::BIT_PERMIT] && !cut &&
      k1 == fwp_pkg::KEY_FIRST && k2 == fwp_pkg::KEY_SECOND;
    wr(8'h14, k1);
    wr(8'h14, k2);
    if (cut) wr(8'h0C, 8'h00);
    wr(8'h18, c);
    rdc("status_busy", 8'h20, {31'h0, busy_exp});
    do tick(n); while (cpu_stall !== 1'b0);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rdc("ctrl_reset", 8'h18, 32'h0);
    rdc("unmapped_rd", 8'h24, 32'h0);
    chk("unmapped_rresp", rsp, 2'h2);
    wr(8'h24, 8'h5A);
    chk("unmapped_bresp", rsp, 2'h2);
    wr(8'h00, 8'hFF);
    chk("bresp_ok", rsp, 2'h0);
    rdc("ptr_upper", 8'h00, 32'h3F);
    chk("rresp_ok", rsp, 2'h0);
    wr(8'h00, 8'h01);
    wr(8'h04, 8'h23);
    wr(8'h08, 8'h46);
    rdc("ptr_high", 8'h04, 32'h23);
    wr(8'h0C, 8'hA5);
    wr(8'h1C, 8'h03);
    rdc("ptr_inc", 8'h08, 32'h47);
    wr(8'h0C, 8'h5C);
    wr(8'h1C, 8'h01);
    rdc("ptr_noinc", 8'h08, 32'h47);
    s_axi_wstrb <= 4'h0;
    wr(8'h0C, 8'hFF);
    s_axi_wstrb <= 4'h1;
    rdc("strb_off", 8'h0C, 32'h5C);
    wr(8'h18, 8'hFF);
    rdc("ctrl_bits", 8'h18, 32'h3C);
    wr(8'h18, 8'h00);
    start(8'h55, 8'hAA, 1'b1, 8'h26);
    start(8'hAA, 8'h55, 1'b0, 8'h26);
    start(8'h55, 8'hAA, 1'b0, 8'h22);
    chk("no_start", u_arr.progs, 0);
    rdc("unlock_rd", 8'h14, 32'h0);
    wr(8'h18, 8'h24);
    start(8'h55, 8'hAA, 1'b0, 8'h26);
    chk("progs", u_arr.progs, 1);
    chk("addr", u_arr.got_addr, 22'h012346);
    chk("word", u_arr.got_word, 16'h5CA5);
    chk("mode", u_arr.got_mode, 1'b1);
    chk("stall_len", u_arr.busy, WC);
    rdc("start_clr", 8'h18, 32'h24);
    start(8'h55, 8'hAA, 1'b0, 8'h26);
    chk("held_word", u_arr.got_word, 16'h5CA5);
    wr(8'h18, 8'h34);
    start(8'h55, 8'hAA, 1'b0, 8'h36);
    chk("erase", flash_erase, 1'b1);
    chk("erase_progs", u_arr.progs, 3);
    for (int k = 0; k < 2; k++) begin
      wr(8'h18, 8'h24);
      wr(8'h14, 8'h55);
      wr(8'h14, 8'hAA);
      wr(8'h18, 8'h26);
      @(posedge aclk);
      if (k == 0) watchdog_reset <= 1'b1;
      else external_master_reset_n <= 1'b0;
      repeat (4) @(posedge aclk);
      watchdog_reset <= 1'b0;
      external_master_reset_n <= 1'b1;
      repeat (WC) @(posedge aclk);
      chk("abort_short", 32'(u_arr.busy < WC), 32'h1);
      rdc("error_flag", 8'h18, 32'h08);
      wr(8'h18, 8'h24);
      start(8'h55, 8'hAA, 1'b0, 8'h26);
      chk("rewrite", u_arr.busy, WC);
    end
    wr(8'h10, 8'h80);
    chk("int_permit", global_interrupt_permit, 1'b1);
    summarize();
  end
endmodule
